/* File: hw/pdg_pkg.sv */
`default_nettype none
package pdg_pkg;
    // =========================================================
    // Widths.
    localparam int unsigned POS_W  = 32;
    localparam int unsigned MAG_W  = 33;
    localparam int unsigned LVL_W  = 30;
    localparam int unsigned SPD_W  = 14;
    localparam int unsigned PCT_W  = 7;
    localparam int unsigned PROD_W = 40;
    localparam int unsigned AW     = 8;
    localparam int unsigned EV_W   = 4;
    localparam int unsigned HTRANS_ACT_BIT = 1;

    // =========================================================
    // Register byte offsets.
    localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
    localparam logic [AW-1:0] OFS_DEV_LVL = 8'h04;
    localparam logic [AW-1:0] OFS_SON_LVL = 8'h08;
    localparam logic [AW-1:0] OFS_WARN    = 8'h0c;
    localparam logic [AW-1:0] OFS_SPD     = 8'h10;
    localparam logic [AW-1:0] OFS_STATUS  = 8'h14;
    localparam logic [AW-1:0] OFS_IRQ_ST  = 8'h18;
    localparam logic [AW-1:0] OFS_IRQ_MSK = 8'h1c;
    localparam logic [AW-1:0] OFS_DEV     = 8'h20;

    // =========================================================
    // Limits and reset values.
    localparam logic [LVL_W-1:0] LVL_RST = 30'h0000_6400;
    localparam logic [SPD_W-1:0] SPD_MAX = 14'h2710;
    localparam logic [SPD_W-1:0] SPD_RST = 14'h2710;
    localparam logic [PCT_W-1:0] PCT_MIN = 7'h0a;
    localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;
    localparam logic [PCT_W-1:0] PCT_RST = 7'h64;
    localparam logic [PCT_W-1:0] PCT_SCALE = 7'h64;

    // =========================================================
    // Field positions.
    localparam int unsigned CTRL_ARST  = 0;
    localparam int unsigned EV_DEV     = 0;
    localparam int unsigned EV_SON     = 1;
    localparam int unsigned EV_SPD     = 2;
    localparam int unsigned EV_WARN    = 3;
    localparam int unsigned ST_SPD_ACT = 4;
    localparam int unsigned ST_SERVO   = 5;
    localparam int unsigned ST_POSMODE = 6;
endpackage
`default_nettype wire

/* File: hw/pdg_dev_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pdg_dev_if;
    import pdg_pkg::*;
    logic [POS_W-1:0] cmd_pos;
    logic [POS_W-1:0] act_pos;
    logic [LVL_W-1:0] dev_lvl;
    logic [LVL_W-1:0] son_lvl;
    logic [PCT_W-1:0] warn_pct;
    logic [POS_W-1:0] dev;
    logic [MAG_W-1:0] dev_mag;
    logic             over_dev;
    logic             over_son;
    logic             over_warn;
    logic             nonzero;

    modport calc (
        input  cmd_pos, act_pos, dev_lvl, son_lvl, warn_pct,
        output dev, dev_mag, over_dev, over_son, over_warn, nonzero
    );
    modport user (
        output cmd_pos, act_pos, dev_lvl, son_lvl, warn_pct,
        input  dev, dev_mag, over_dev, over_son, over_warn, nonzero
    );
endinterface
`default_nettype wire

/* File: hw/pdg_dev_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module pdg_dev_calc (
    pdg_dev_if.calc dv
);
    import pdg_pkg::*;

    logic [MAG_W-1:0]  diff;
    logic [PROD_W-1:0] mag_scaled;
    logic [PROD_W-1:0] warn_thr;

    // =========================================================
    // Signed deviation and its magnitude.
    assign diff = {dv.cmd_pos[POS_W-1], dv.cmd_pos}
                - {dv.act_pos[POS_W-1], dv.act_pos};
    assign dv.dev     = diff[POS_W-1:0];
    assign dv.dev_mag = diff[MAG_W-1] ? MAG_W'(-diff) : diff;
    assign dv.nonzero = |dv.dev_mag;

    // =========================================================
    // Level comparisons.
    assign dv.over_dev = dv.dev_mag > MAG_W'(dv.dev_lvl);
    assign dv.over_son = dv.dev_mag > MAG_W'(dv.son_lvl);
    assign mag_scaled  = PROD_W'(dv.dev_mag) * PROD_W'(PCT_SCALE);
    assign warn_thr    = PROD_W'(dv.son_lvl) * PROD_W'(dv.warn_pct);
    assign dv.over_warn = mag_scaled > warn_thr;
endmodule
`default_nettype wire

/* File: hw/pdg_guard.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Overflow checks armed only in position control.
// - Deviation equals commanded minus actual position.
// - Deviation above level raises alarm, stops motor.
// - Overflow level 1..1073741823, default 25600, immediate.
// - Servo-off deviation above level alarms at servo on.
// - Servo-on level 1..1073741823, default 25600, immediate.
// - Clamp speed while residual deviation after servo on.
// - Limited, pulses arriving, overflow level exceeded: alarm.
// - Speed limit 0..10000 rpm, default 10000, immediate.
// - Warning level 10..100 percent, default 100, immediate.
module pdg_guard (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire logic                  pos_mode,
    input  wire logic                  servo_on,
    input  wire logic [pdg_pkg::POS_W-1:0] cmd_pos,
    input  wire logic [pdg_pkg::POS_W-1:0] act_pos,
    input  wire logic                  ref_pulse_pin,
    output logic                       motor_stop,
    output logic                       speed_limit_en,
    output logic [pdg_pkg::SPD_W-1:0]  servo_on_speed_limit,
    output logic                       servo_on_warning,
    output logic                       deviation_overflow_alarm,
    output logic                       servo_on_overflow_alarm,
    output logic                       servo_on_speed_limit_alarm,
    output logic                       irq
);
    import pdg_pkg::*;

    // =========================================================
    // Declarations.
    pdg_dev_if dv ();

    logic             hreadyout_r;
    logic [31:0]      hrdata_r;
    logic             hresp_r;
    logic             wr_pend_r;
    logic [AW-1:0]    addr_r;
    logic [LVL_W-1:0] dev_lvl_r;
    logic [LVL_W-1:0] son_lvl_r;
    logic [PCT_W-1:0] warn_pct_r;
    logic [SPD_W-1:0] spd_r;
    logic [EV_W-1:0]  irq_st_r;
    logic [EV_W-1:0]  irq_msk_r;
    logic             irq_r;
    logic             alm_dev_r;
    logic             alm_son_r;
    logic             alm_spd_r;
    logic             warn_r;
    logic             stop_r;
    logic             spd_act_r;
    logic             son_prev_r;
    logic             ref_s1_r;
    logic             ref_s2_r;
    logic             ref_s3_r;
    logic             ref_lvl_r;

    logic             addr_ph;
    logic             wr_ph;
    logic             arst;
    logic             irq_clr;
    logic             son_rise;
    logic             pulse_evt;
    logic             dev_trip;
    logic             son_trip;
    logic             spd_trip;
    logic             warn_trip;
    logic             lvl_ok;
    logic [EV_W-1:0]  ev;
    logic [31:0]      rd_word;

    // =========================================================
    // Deviation datapath.
    assign dv.cmd_pos  = cmd_pos;
    assign dv.act_pos  = act_pos;
    assign dv.dev_lvl  = dev_lvl_r;
    assign dv.son_lvl  = son_lvl_r;
    assign dv.warn_pct = warn_pct_r;

    pdg_dev_calc u_calc (
        .dv (dv)
    );

    // =========================================================
    // Bus decode.
    assign addr_ph = hsel && hready && htrans[HTRANS_ACT_BIT];
    assign wr_ph   = wr_pend_r;
    assign arst    = wr_ph && (addr_r == OFS_CTRL) && hwdata[CTRL_ARST];
    assign irq_clr = addr_ph && !hwrite && (haddr[AW-1:0] == OFS_IRQ_ST);
    assign lvl_ok  = (hwdata[31:LVL_W] == '0) && (hwdata[LVL_W-1:0] != '0);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[AW-1:0])
            OFS_DEV_LVL: rd_word[LVL_W-1:0] = dev_lvl_r;
            OFS_SON_LVL: rd_word[LVL_W-1:0] = son_lvl_r;
            OFS_WARN:    rd_word[PCT_W-1:0] = warn_pct_r;
            OFS_SPD:     rd_word[SPD_W-1:0] = spd_r;
            OFS_STATUS: begin
                rd_word[EV_DEV]     = alm_dev_r;
                rd_word[EV_SON]     = alm_son_r;
                rd_word[EV_SPD]     = alm_spd_r;
                rd_word[EV_WARN]    = warn_r;
                rd_word[ST_SPD_ACT] = spd_act_r;
                rd_word[ST_SERVO]   = servo_on;
                rd_word[ST_POSMODE] = pos_mode;
            end
            OFS_IRQ_ST:  rd_word[EV_W-1:0] = irq_st_r;
            OFS_IRQ_MSK: rd_word[EV_W-1:0] = irq_msk_r;
            OFS_DEV:     rd_word = dv.dev;
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
            hrdata_r    <= 32'h0000_0000;
            wr_pend_r   <= 1'b0;
            addr_r      <= '0;
        end else begin
            wr_pend_r   <= addr_ph && hwrite;
            if (addr_ph) begin
                addr_r <= haddr[AW-1:0];
                if (!hwrite) begin
                    hrdata_r <= rd_word;
                end
            end
        end
    end

    // =========================================================
    // Configuration registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_lvl_r  <= LVL_RST;
            son_lvl_r  <= LVL_RST;
            warn_pct_r <= PCT_RST;
            spd_r      <= SPD_RST;
            irq_msk_r  <= '0;
        end else if (wr_ph) begin
            if (addr_r == OFS_DEV_LVL && lvl_ok) begin
                dev_lvl_r <= hwdata[LVL_W-1:0];
            end
            if (addr_r == OFS_SON_LVL && lvl_ok) begin
                son_lvl_r <= hwdata[LVL_W-1:0];
            end
            if (addr_r == OFS_WARN && hwdata[31:PCT_W] == '0
                && hwdata[PCT_W-1:0] >= PCT_MIN
                && hwdata[PCT_W-1:0] <= PCT_MAX) begin
                warn_pct_r <= hwdata[PCT_W-1:0];
            end
            if (addr_r == OFS_SPD && hwdata[31:SPD_W] == '0
                && hwdata[SPD_W-1:0] <= SPD_MAX) begin
                spd_r <= hwdata[SPD_W-1:0];
            end
            if (addr_r == OFS_IRQ_MSK) begin
                irq_msk_r <= hwdata[EV_W-1:0];
            end
        end
    end

    // =========================================================
    // Reference pulse pin synchroniser and edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_s1_r  <= 1'b0;
            ref_s2_r  <= 1'b0;
            ref_s3_r  <= 1'b0;
            ref_lvl_r <= 1'b0;
        end else begin
            ref_s1_r <= ref_pulse_pin;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            if (ref_s2_r == ref_s3_r) begin
                ref_lvl_r <= ref_s3_r;
            end
        end
    end

    assign pulse_evt = (ref_s2_r == ref_s3_r) && ref_s3_r && !ref_lvl_r;

    // =========================================================
    // Protection conditions.
    assign son_rise  = servo_on && !son_prev_r;
    assign dev_trip  = pos_mode && servo_on && dv.over_dev;
    assign son_trip  = pos_mode && son_rise && dv.over_son;
    assign spd_trip  = pos_mode && spd_act_r && pulse_evt
                       && dv.over_dev;
    assign warn_trip = pos_mode && son_rise && dv.over_warn;

    always_ff @(posedge clk) begin
        if (rst) begin
            son_prev_r <= 1'b0;
        end else begin
            son_prev_r <= servo_on;
        end
    end

    // =========================================================
    // Servo-on speed limit.
    always_ff @(posedge clk) begin
        if (rst) begin
            spd_act_r <= 1'b0;
        end else if (!servo_on || !pos_mode || !dv.nonzero) begin
            spd_act_r <= 1'b0;
        end else if (son_rise) begin
            spd_act_r <= 1'b1;
        end
    end

    // =========================================================
    // Latched alarms, warning and motor stop.
    always_ff @(posedge clk) begin
        if (rst) begin
            alm_dev_r <= 1'b0;
            alm_son_r <= 1'b0;
            alm_spd_r <= 1'b0;
            warn_r    <= 1'b0;
            stop_r    <= 1'b0;
        end else begin
            alm_dev_r <= dev_trip || (alm_dev_r && !arst);
            alm_son_r <= son_trip || (alm_son_r && !arst);
            alm_spd_r <= spd_trip || (alm_spd_r && !arst);
            warn_r    <= warn_trip || (warn_r && !arst && servo_on);
            stop_r    <= dev_trip || son_trip || spd_trip
                         || ((alm_dev_r || alm_son_r || alm_spd_r)
                             && !arst);
        end
    end

    // =========================================================
    // Interrupt status, read to clear.
    assign ev[EV_DEV]  = dev_trip && !alm_dev_r;
    assign ev[EV_SON]  = son_trip && !alm_son_r;
    assign ev[EV_SPD]  = spd_trip && !alm_spd_r;
    assign ev[EV_WARN] = warn_trip && !warn_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_st_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~{EV_W{irq_clr}}) | ev;
            irq_r    <= |(((irq_st_r & ~{EV_W{irq_clr}}) | ev) & irq_msk_r);
        end
    end

    // =========================================================
    // Outputs.
    assign hreadyout                  = hreadyout_r;
    assign hrdata                     = hrdata_r;
    assign hresp                      = hresp_r;
    assign motor_stop                 = stop_r;
    assign speed_limit_en             = spd_act_r;
    assign servo_on_speed_limit       = spd_r;
    assign servo_on_warning           = warn_r;
    assign deviation_overflow_alarm   = alm_dev_r;
    assign servo_on_overflow_alarm    = alm_son_r;
    assign servo_on_speed_limit_alarm = alm_spd_r;
    assign irq                        = irq_r;

    // =========================================================
    // Assertions.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wr_at(logic [AW-1:0] ofs);
        wr_pend_r && (addr_r == ofs);
    endsequence
    sequence s_lvl_valid;
        (hwdata[31:LVL_W] == '0) && (hwdata[LVL_W-1:0] != '0);
    endsequence
    sequence s_son_entry;
        pos_mode && servo_on && !son_prev_r;
    endsequence

    property p_mode_gate;
        $rose(alm_dev_r) |-> $past(pos_mode) && $past(servo_on);
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("Overflow alarm raised outside position control.");

    property p_dev_zero;
        (dv.dev_mag == '0) == (cmd_pos == act_pos);
    endproperty
    a_dev_zero: assert property (p_dev_zero)
        else $error("Deviation magnitude disagrees with positions.");

    property p_dev_trip;
        pos_mode && servo_on && dv.over_dev |=> alm_dev_r && motor_stop;
    endproperty
    a_dev_trip: assert property (p_dev_trip)
        else $error("Deviation overflow did not alarm and stop.");

    property p_dev_lvl_wr;
        s_wr_at(OFS_DEV_LVL) ##0 s_lvl_valid
            |=> dev_lvl_r == $past(hwdata[LVL_W-1:0]);
    endproperty
    a_dev_lvl_wr: assert property (p_dev_lvl_wr)
        else $error("Overflow level write not applied.");

    property p_son_trip;
        s_son_entry ##0 dv.over_son |=> alm_son_r ##1 (alm_son_r || $past(arst));
    endproperty
    a_son_trip: assert property (p_son_trip)
        else $error("Servo-on overflow alarm missing.");

    property p_son_lvl_wr;
        s_wr_at(OFS_SON_LVL) ##0 !lvl_ok |=> $stable(son_lvl_r);
    endproperty
    a_son_lvl_wr: assert property (p_son_lvl_wr)
        else $error("Out-of-range servo-on level was taken.");

    property p_spd_on;
        s_son_entry ##0 dv.nonzero |=> speed_limit_en;
    endproperty
    a_spd_on: assert property (p_spd_on)
        else $error("Speed limit not engaged at servo on.");

    property p_spd_trip;
        spd_act_r && pos_mode && pulse_evt && dv.over_dev
            |=> servo_on_speed_limit_alarm;
    endproperty
    a_spd_trip: assert property (p_spd_trip)
        else $error("Speed-limit alarm missing.");

    property p_spd_wr;
        s_wr_at(OFS_SPD) ##0 (hwdata[31:0] <= 32'(SPD_MAX))
            |=> servo_on_speed_limit == $past(hwdata[SPD_W-1:0]);
    endproperty
    a_spd_wr: assert property (p_spd_wr)
        else $error("Speed limit write not applied.");

    property p_warn_rng;
        warn_pct_r >= PCT_MIN && warn_pct_r <= PCT_MAX;
    endproperty
    a_warn_rng: assert property (p_warn_rng)
        else $error("Warning level outside its range.");

    property p_latch;
        alm_dev_r && !arst |=> alm_dev_r;
    endproperty
    a_latch: assert property (p_latch)
        else $error("Alarm dropped without alarm reset.");

    property p_irq;
        irq == |(irq_st_r & $past(irq_msk_r));
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt output disagrees with status and mask.");
endmodule
`default_nettype wire

/* File: tb/pdg_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// Host reference source and encoder feedback model.
module pdg_partner (
    input  wire logic                      clk,
    input  wire logic [pdg_pkg::POS_W-1:0] cmd_in,
    input  wire logic [pdg_pkg::POS_W-1:0] act_in,
    input  wire logic                      pulse_req,
    output logic      [pdg_pkg::POS_W-1:0] cmd_pos,
    output logic      [pdg_pkg::POS_W-1:0] act_pos,
    output logic                           ref_pulse_pin
);
    import pdg_pkg::*;
    logic [3:0] cnt = 4'h0;

    // The host commands a position and the encoder reports one.
    assign cmd_pos = cmd_in;
    assign act_pos = act_in;

    // Each request taken while the counter is idle makes one pulse, four cycles high then four low.
    always @(posedge clk) begin
        if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pulse_req) begin
            cnt <= 4'h8;
        end
    end
    assign ref_pulse_pin = (cnt > 4'h4);
endmodule
`default_nettype wire

/* File: tb/pdg_guard_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pdg_guard_tb;
    import pdg_pkg::*;
    // =========================================================
    // Signals.
    localparam logic [31:0] B_DEV  = 32'h1 << EV_DEV;
    localparam logic [31:0] B_SON  = 32'h1 << EV_SON;
    localparam logic [31:0] B_SPD  = 32'h1 << EV_SPD;
    localparam logic [31:0] B_WARN = 32'h1 << EV_WARN;
    localparam logic [31:0] B_LIM  = 32'h1 << ST_SPD_ACT;
    localparam logic [31:0] B_ON   = (32'h1 << ST_SERVO)
                                   | (32'h1 << ST_POSMODE);
    logic              clk       = 1'b0;
    logic              rst       = 1'b1;
    logic              hsel      = 1'b0;
    logic              hwrite    = 1'b0;
    logic        [1:0] htrans    = 2'b00;
    logic       [31:0] haddr     = 32'h0;
    logic       [31:0] hwdata    = 32'h0;
    logic              pos_mode  = 1'b0;
    logic              servo_on  = 1'b0;
    logic              pulse_req = 1'b0;
    logic [POS_W-1:0]  cmd_in    = '0;
    logic [POS_W-1:0]  act_in    = '0;
    logic              hready;
    logic       [31:0] hrdata;
    logic              hresp;
    logic [POS_W-1:0]  cmd_pos;
    logic [POS_W-1:0]  act_pos;
    logic              ref_pin;
    logic              motor_stop;
    logic              lim_en;
    logic [SPD_W-1:0]  spd_lim;
    logic              warn;
    logic              dev_al;
    logic              son_al;
    logic              spd_al;
    logic              irq;
    logic              rd_dph    = 1'b0;
    logic       [31:0] e;
    logic       [31:0] lv;
    logic       [31:0] expq [$];
    int                n_errors     = 0;
    int                total_checks = 0;
    logic [AW-1:0] ta [11] = '{OFS_DEV_LVL, OFS_DEV_LVL, OFS_DEV_LVL,
        OFS_SON_LVL, OFS_SON_LVL, OFS_SON_LVL, OFS_WARN, OFS_WARN, OFS_WARN,
        OFS_SPD, OFS_SPD};
    logic   [31:0] tw [11] = '{32'h0, 32'h3fffffff, 32'h1, 32'h0,
        32'h3fffffff, 32'h1, 32'h9, 32'ha, 32'h65, 32'h2711, 32'h0};
    logic   [31:0] te [11] = '{32'h6400, 32'h3fffffff, 32'h1, 32'h6400,
        32'h3fffffff, 32'h1, 32'h64, 32'ha, 32'ha, 32'h2710, 32'h0};

    always #2 clk = ~clk;

    pdg_guard i_dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .pos_mode(pos_mode), .servo_on(servo_on), .cmd_pos(cmd_pos),
        .act_pos(act_pos), .ref_pulse_pin(ref_pin), .motor_stop(motor_stop),
        .speed_limit_en(lim_en), .servo_on_speed_limit(spd_lim),
        .servo_on_warning(warn), .deviation_overflow_alarm(dev_al),
        .servo_on_overflow_alarm(son_al),
        .servo_on_speed_limit_alarm(spd_al), .irq(irq)
    );

    pdg_partner i_far (
        .clk(clk), .cmd_in(cmd_in), .act_in(act_in), .pulse_req(pulse_req),
        .cmd_pos(cmd_pos), .act_pos(act_pos), .ref_pulse_pin(ref_pin)
    );

    // =========================================================
    // Checking.
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] ex);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic ex);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The read data of each finished read is matched to the oldest note.
    always @(posedge clk) begin
        if (rd_dph && hready) begin
            if (expq.size() == 0) begin
                n_errors++;
            end else begin
                e = expq.pop_front();
                cmp_word(hrdata, e);
                cmp_bit(hresp, 1'b0);
            end
        end
        rd_dph <= hsel && hready && htrans[1] && !hwrite;
    end

    // =========================================================
    // Bus and stimulus tasks.
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 16) begin
                n_errors++;
                complete_run();
            end
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic w, input logic [AW-1:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [31:0] x);
        expq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask

    // Four edges cover the alarm latency and the register update.
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic setp(input logic pm, input logic so, input logic [31:0] d);
        logic [31:0] b;
        b = $urandom >> 2;
        @(posedge clk);
        pos_mode <= pm;
        servo_on <= so;
        act_in <= b;
        cmd_in <= b + d;
        settle();
    endtask

    task automatic tend(input int n);
        $display("test %0d done", n);
    endtask

    // =========================================================
    // Main sequence.
    initial begin
        void'($urandom(32'hb38c));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_DEV_LVL, {2'b0, LVL_RST});
        rd(OFS_SON_LVL, {2'b0, LVL_RST});
        rd(OFS_WARN, {25'h0, PCT_RST});
        rd(OFS_SPD, {18'h0, SPD_RST});
        rd(OFS_STATUS, 32'h0);
        rd(8'h24, 32'h0);
        tend(1);
        for (int i = 0; i < 11; i++) begin
            wr(ta[i], tw[i]);
            rd(ta[i], te[i]);
        end
        settle();
        cmp_word({18'h0, spd_lim}, 32'h0);
        tend(2);
        lv = 32'($urandom % 900) + 32'h64;
        wr(OFS_DEV_LVL, lv);
        setp(1'b0, 1'b1, -(lv + 32'h5));
        rd(OFS_STATUS, 32'h1 << ST_SERVO);
        cmp_bit(motor_stop, 1'b0);
        tend(3);
        setp(1'b0, 1'b0, 32'h0);
        setp(1'b1, 1'b1, 32'h0);
        setp(1'b1, 1'b1, lv);
        rd(OFS_STATUS, B_ON);
        rd(OFS_DEV, lv);
        setp(1'b1, 1'b1, -(lv + 32'h1));
        rd(OFS_DEV, -(lv + 32'h1));
        rd(OFS_STATUS, B_DEV | B_ON);
        cmp_bit(motor_stop, 1'b1);
        cmp_bit(dev_al, 1'b1);
        cmp_bit(irq, 1'b0);
        wr(OFS_IRQ_MSK, 32'h1);
        settle();
        cmp_bit(irq, 1'b1);
        rd(OFS_IRQ_ST, B_DEV);
        rd(OFS_IRQ_ST, 32'h0);
        settle();
        cmp_bit(irq, 1'b0);
        setp(1'b1, 1'b1, 32'h0);
        rd(OFS_STATUS, B_DEV | B_ON);
        wr(OFS_CTRL, 32'h1);
        settle();
        rd(OFS_STATUS, B_ON);
        cmp_bit(motor_stop, 1'b0);
        tend(4);
        wr(OFS_SON_LVL, 32'h32);
        wr(OFS_DEV_LVL, 32'h3e8);
        setp(1'b1, 1'b0, 32'h33);
        setp(1'b1, 1'b1, 32'h33);
        rd(OFS_STATUS, B_SON | B_WARN | B_LIM | B_ON);
        cmp_bit(son_al, 1'b1);
        cmp_bit(lim_en, 1'b1);
        cmp_bit(warn, 1'b1);
        cmp_bit(irq, 1'b0);
        setp(1'b1, 1'b1, 32'h0);
        rd(OFS_STATUS, B_SON | B_WARN | B_ON);
        wr(OFS_CTRL, 32'h1);
        settle();
        rd(OFS_STATUS, B_ON);
        tend(5);
        setp(1'b1, 1'b0, 32'h32);
        setp(1'b1, 1'b1, 32'h32);
        rd(OFS_STATUS, B_WARN | B_LIM | B_ON);
        setp(1'b1, 1'b1, 32'h3e9);
        rd(OFS_STATUS, B_DEV | B_WARN | B_LIM | B_ON);
        cmp_bit(spd_al, 1'b0);
        @(posedge clk);
        pulse_req <= 1'b1;
        @(posedge clk);
        pulse_req <= 1'b0;
        repeat (4) settle();
        rd(OFS_STATUS, B_DEV | B_SPD | B_WARN | B_LIM | B_ON);
        cmp_bit(spd_al, 1'b1);
        rd(OFS_IRQ_ST, B_DEV | B_SON | B_SPD | B_WARN);
        tend(6);
        settle();
        complete_run();
    end

    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
